/* logic/can_boot_pkg.sv */
// Constants and types of the CAN boot bit rate loader
`default_nettype none
package can_boot_pkg;
  localparam int          ADDR_W        = 18;
  localparam logic [15:0] IDX_CTRL      = 16'hef00;
  localparam logic [15:0] IDX_BTR       = 16'hef06;
  localparam logic [15:0] IDX_SYS       = 16'hef10;
  localparam logic [15:0] IDX_BUS       = 16'hef11;
  localparam logic [15:0] IDX_PERIPH    = 16'hef12;
  localparam logic [15:0] IDX_STATUS    = 16'hef13;
  localparam logic [15:0] IDX_COUNT     = 16'hef14;
  localparam logic [15:0] IDX_UART      = 16'hef15;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [15:0] SYS_BOOT      = 16'h0404;
  localparam logic [15:0] PERIPH_BOOT   = 16'h042d;
  localparam logic [15:0] CTRL_BOOT     = 16'h0000;
  localparam logic [15:0] BUS_OFF       = 16'h0000;
  localparam int          MEM_EN_BIT    = 10;
  localparam int          HIGH_DIS_BIT  = 9;
  localparam int          BUS_ACT_BIT   = 10;
  localparam int          LATCH_LEN_BIT = 9;
  localparam int          BUS_TYPE_LSB  = 6;
  localparam int          EXT_PERIPH_ENABLE_BIT      = 2;
  localparam int          CAN_EN_BIT    = 3;
  localparam logic [15:0] RAM_BASE      = 16'hfa40;
  localparam logic [15:0] RAM_LAST      = 16'hfabf;
  localparam int          LOAD_BYTES    = 128;
  localparam int          BRP_DIV       = 1451;
  localparam int          MIN_COUNT     = 464;
  localparam int          TQ_TICKS      = 58;
  localparam int          BRP_MAX       = 63;
  localparam int          TQ_MIN        = 8;
  localparam int          TQ_MAX        = 25;
  localparam logic [1:0]  SJW_CODE      = 2'h1;
  localparam logic [2:0]  STUFF_LAST    = 3'h5;
  localparam int          POLL_ERR      = 6;
  localparam logic [2:0]  SETTLE_CYC    = 3'h3;
  localparam logic [10:0] ACK_ID        = 11'h0e6;
  localparam logic [3:0]  ACK_DLC       = 4'h3;
  localparam logic [10:0] LOAD_ID       = 11'h005;
  localparam logic [23:0] FLASH_LO      = 24'h010000;
  localparam logic [23:0] FLASH_HI      = 24'h08ffff;

  typedef enum logic [3:0] {
    ST_STRAP = 4'h0, ST_POLL = 4'h1, ST_DOM = 4'h3, ST_REC = 4'h2,
    ST_CALC = 4'h6, ST_LOAD = 4'h7, ST_RUN = 4'h5, ST_UART = 4'h4,
    ST_NORMAL = 4'hc
  } state_t;

  typedef struct packed { logic we; logic [15:0] addr; logic [7:0] data; } ram_wr_t;
  typedef struct packed { logic valid; logic [10:0] id; logic [3:0] dlc; logic [23:0] data; } ack_obj_t;
  typedef struct packed { logic valid; logic [10:0] id; logic [7:0] data; } rx_frame_t;
  typedef struct packed { logic req; logic code; logic [23:0] addr; } fetch_t;
endpackage : can_boot_pkg
`default_nettype wire

/* logic/can_boot_bitrate_loader.sv */
// CAN boot loader: startup config, zero frame timing, bit timing, code load
// Function
// R1: Boot mode keeps watchdog disabled
// R2: Peripheral select loaded with 042D on entry
// R3: CAN boot clears control, sets tx, bit timing
// R4: Transmit pin switched to output
// R5: No code execution from main flash
// R6: Memory enable forced, high byte from port0
// R7: External access high clears bus config
// R8: Access low sets bus bits, type from port0
// R9: Exactly 128 data bytes received
// R10: Bytes stored from FA40 to FABF
// R11: Branch to first byte, stay in boot
// R12: Code fetches in flash go to test flash
// R13: Poll UART and CAN receive lines
// R14: Host sends zero frame, known stuff pattern
// R15: Stop timer at fifth recessive stuff bit
// R16: Timer advances once per clock
// R17: Polling error at most six clocks
// R18: Bit time between 8 and 25 quanta
// R19: Prescaler is count divided by 1451
// R20: Segment table gives 70-80 percent sample (code: 68 percent at 25 quanta)
// R21: Jump width fixed at two quanta
// R22: Round quotient up past half divisor
// R23: Acknowledge object prepared, not transmitted
// R24: Accept only identifier 5, one byte
//
// Implementation choice: the AXI4-Lite slave port.
`default_nettype none
module can_boot_bitrate_loader #(
  parameter int          TIMER_W    = 16,
  parameter logic [15:0] CHIP_IDENT = 16'h0a5c,  // Arbitrary value
  parameter logic [7:0]  ACK_CODE   = 8'h3c      // Arbitrary value
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [can_boot_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        wvalid,
  output logic                             wready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  output logic                             bvalid,
  input  wire logic                        bready,
  output logic [1:0]                       bresp,
  input  wire logic                        arvalid,
  output logic                             arready,
  input  wire logic [can_boot_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                  arprot,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  input  wire logic                        boot_select_n,
  input  wire logic                        external_access_pin,
  input  wire logic                        bus_width_pin,
  input  wire logic [1:0]                  bus_type_pins,
  input  wire logic                        uart_rx_pin,
  input  wire logic                        can_rx_pin,
  output logic                             can_tx_pin,
  output logic                             can_tx_oe,
  input  wire can_boot_pkg::rx_frame_t     rx_frame,
  input  wire can_boot_pkg::fetch_t        fetch,
  output logic                             fetch_to_test_flash,
  output can_boot_pkg::ram_wr_t            ram_wr,
  output logic                             branch_start,
  output can_boot_pkg::ack_obj_t           ack_obj,
  output logic                             boot_mode,
  output logic                             watchdog_disable,
  output logic [15:0]                      system_config,
  output logic [15:0]                      bus_config_zero,
  output logic [15:0]                      periph_select,
  output logic [15:0]                      can_control_status,
  output logic [15:0]                      can_bit_timing
);
  import can_boot_pkg::*;

  if (TIMER_W < 11 || TIMER_W > 24) begin : g_check
    $error("TIMER_W must lie between 11 and 24");
  end

  typedef struct packed {
    state_t               state;
    logic [2:0]           settle;
    logic [6:0]           s1;
    logic [6:0]           s2;
    logic                 boot;
    logic [TIMER_W-1:0]   count;
    logic [TIMER_W-1:0]   uart_count;
    logic [2:0]           stuff;
    logic                 bad_rate;
    logic [15:0]          sys_cfg;
    logic [15:0]          bus_cfg;
    logic [15:0]          periph;
    logic [15:0]          ctrl;
    logic [15:0]          btr;
    logic                 tx_latch;
    logic                 tx_dir;
    logic [7:0]           loaded;
    ram_wr_t              ram;
    logic                 branch;
    logic                 redirect;
    ack_obj_t             ack;
    logic                 aw_have;
    logic                 w_have;
    logic [ADDR_W-1:0]    awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } st_t;

  st_t st_reg;
  st_t st_next;

  function automatic logic [3:0] seg_two_len(input logic [4:0] tq);
    logic [4:0] a;
    logic [4:0] b;
    a = (tq + 5'd4) / 5'd5;
    b = (tq > 5'd17) ? tq - 5'd17 : 5'd0;
    return (a > b) ? a[3:0] : b[3:0];
  endfunction : seg_two_len

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge

  always_comb begin
    logic [TIMER_W-1:0] brp_q;
    logic [TIMER_W-1:0] tq_div;
    logic [TIMER_W-1:0] quo;
    logic [TIMER_W-1:0] rem;
    logic [3:0]         segment_two_len;
    logic [3:0]         segment_one_len;
    logic               rate_ok;
    logic [15:0]        widx;
    logic [15:0]        ridx;
    logic [15:0]        rval;
    logic               rhit;
    brp_q   = '0;
    tq_div  = '0;
    quo     = '0;
    rem     = '0;
    segment_two_len   = '0;
    segment_one_len   = '0;
    rate_ok = 1'b0;
    widx    = st_reg.awaddr[ADDR_W-1:2];
    ridx    = araddr[ADDR_W-1:2];
    rval    = '0;
    rhit    = 1'b1;
    st_next = st_reg;
    st_next.s1 = {boot_select_n, external_access_pin, bus_width_pin, bus_type_pins, uart_rx_pin, can_rx_pin};
    st_next.s2 = st_reg.s1;
    st_next.branch = 1'b0;
    st_next.ram.we = 1'b0;
    st_next.redirect = st_reg.boot && fetch.req && fetch.code
                       && fetch.addr >= FLASH_LO && fetch.addr <= FLASH_HI;  // R5 R12
    unique case (st_reg.state)
      ST_STRAP: begin
        st_next.settle = st_reg.settle + 3'h1;
        if (st_reg.settle == SETTLE_CYC) begin
          st_next.boot = !st_reg.s2[6];
          if (!st_reg.s2[6]) begin
            st_next.state = ST_POLL;
            st_next.sys_cfg = SYS_BOOT;
            st_next.sys_cfg[MEM_EN_BIT] = 1'b1;  // R6
            st_next.sys_cfg[HIGH_DIS_BIT] = st_reg.s2[4];  // R6
            st_next.periph = PERIPH_BOOT;  // R2
            if (st_reg.s2[5]) begin
              st_next.bus_cfg = BUS_OFF;  // R7
            end else begin
              st_next.bus_cfg = BUS_OFF;
              st_next.bus_cfg[BUS_ACT_BIT] = 1'b1;  // R8
              st_next.bus_cfg[LATCH_LEN_BIT] = 1'b1;  // R8
              st_next.bus_cfg[BUS_TYPE_LSB+:2] = st_reg.s2[3:2];  // R8
            end
          end else begin
            st_next.state = ST_NORMAL;
          end
        end
      end
      ST_POLL: begin
        st_next.count = '0;
        st_next.stuff = '0;
        if (!st_reg.s2[0]) begin
          st_next.state = ST_DOM;  // R13
          st_next.count = TIMER_W'(1);
        end else if (!st_reg.s2[1]) begin
          st_next.state = ST_UART;  // R13
          st_next.count = TIMER_W'(1);
        end
      end
      ST_UART: begin
        st_next.count = st_reg.count + TIMER_W'(1);
        if (st_reg.s2[1]) begin
          st_next.uart_count = st_reg.count;  // R13
          st_next.state = ST_POLL;
        end else if (&st_reg.count) begin
          st_next.state = ST_POLL;
        end
      end
      ST_DOM: begin
        st_next.count = st_reg.count + TIMER_W'(1);  // R16
        if (st_reg.s2[0]) begin
          st_next.count = st_reg.count;  // R17
          st_next.stuff = st_reg.stuff + 3'h1;  // R14
          st_next.state = (st_reg.stuff == STUFF_LAST - 3'h1) ? ST_CALC : ST_REC;  // R15
        end else if (&st_reg.count) begin
          st_next.state = ST_POLL;
        end
      end
      ST_REC: begin
        st_next.count = st_reg.count + TIMER_W'(1);  // R16
        if (!st_reg.s2[0]) begin
          st_next.state = ST_DOM;
        end else if (&st_reg.count) begin
          st_next.state = ST_POLL;
        end
      end
      ST_CALC: begin
        brp_q  = st_reg.count / TIMER_W'(BRP_DIV);  // R19
        tq_div = TIMER_W'(TQ_TICKS) * (brp_q + TIMER_W'(1));
        quo    = st_reg.count / tq_div;
        rem    = st_reg.count % tq_div;
        if ({rem, 1'b0} > {1'b0, tq_div}) begin
          quo = quo + TIMER_W'(1);  // R22
        end
        rate_ok = st_reg.count >= TIMER_W'(MIN_COUNT) && brp_q <= TIMER_W'(BRP_MAX)
                  && quo >= TIMER_W'(TQ_MIN) && quo <= TIMER_W'(TQ_MAX);  // R18 R19
        segment_two_len = seg_two_len(quo[4:0]);  // R20
        segment_one_len = 4'(quo[4:0] - 5'd1 - {1'b0, segment_two_len});
        if (rate_ok) begin
          st_next.btr = {1'b0, 3'(segment_two_len - 4'h1), 4'(segment_one_len - 4'h1), SJW_CODE, brp_q[5:0]};  // R3 R20 R21
          st_next.ctrl = CTRL_BOOT;  // R3
          st_next.tx_latch = 1'b1;  // R3
          st_next.tx_dir = 1'b1;  // R4
          st_next.ack = '{valid: 1'b1, id: ACK_ID, dlc: ACK_DLC, data: {CHIP_IDENT, ACK_CODE}};  // R23
          st_next.loaded = '0;
          st_next.bad_rate = 1'b0;
          st_next.state = ST_LOAD;
        end else begin
          st_next.bad_rate = 1'b1;
          st_next.state = ST_POLL;
        end
      end
      ST_LOAD: begin
        if (st_reg.loaded == 8'(LOAD_BYTES)) begin
          st_next.branch = 1'b1;  // R11
          st_next.state = ST_RUN;
        end else if (rx_frame.valid && rx_frame.id == LOAD_ID
                     && st_reg.periph[CAN_EN_BIT] && st_reg.sys_cfg[EXT_PERIPH_ENABLE_BIT]) begin  // R24
          st_next.ram = '{we: 1'b1, addr: RAM_BASE + {8'h00, st_reg.loaded}, data: rx_frame.data};  // R10
          st_next.loaded = st_reg.loaded + 8'h1;  // R9
        end
      end
      ST_RUN: begin
        st_next.state = ST_RUN;  // R11
      end
      ST_NORMAL: begin
        st_next.state = ST_NORMAL;
      end
      default: begin
        st_next.state = ST_STRAP;
      end
    endcase
    if (awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = wdata;
      st_next.wstrb = wstrb;
    end
    if (bready && st_reg.bvalid) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (widx)
        IDX_CTRL:   st_next.ctrl = merge(st_reg.ctrl, st_reg.wdata, st_reg.wstrb);
        IDX_BTR:    st_next.btr = merge(st_reg.btr, st_reg.wdata, st_reg.wstrb);
        IDX_SYS:    st_next.sys_cfg = merge(st_reg.sys_cfg, st_reg.wdata, st_reg.wstrb);
        IDX_BUS:    st_next.bus_cfg = merge(st_reg.bus_cfg, st_reg.wdata, st_reg.wstrb);
        IDX_PERIPH: st_next.periph = merge(st_reg.periph, st_reg.wdata, st_reg.wstrb);
        IDX_STATUS, IDX_COUNT, IDX_UART: st_next.bresp = RESP_OKAY;
        default:    st_next.bresp = RESP_SLVERR;
      endcase
    end
    case (ridx)
      IDX_CTRL:   rval = st_reg.ctrl;
      IDX_BTR:    rval = st_reg.btr;
      IDX_SYS:    rval = st_reg.sys_cfg;
      IDX_BUS:    rval = st_reg.bus_cfg;
      IDX_PERIPH: rval = st_reg.periph;
      IDX_STATUS: rval = {st_reg.loaded, 2'h0, st_reg.bad_rate, st_reg.boot, st_reg.state};
      IDX_COUNT:  rval = 16'(st_reg.count);
      IDX_UART:   rval = 16'(st_reg.uart_count);
      default:    rhit = 1'b0;
    endcase
    if (rready && st_reg.rvalid) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = {16'h0000, rval};
      st_next.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready             = st_reg.awready;
  assign wready              = st_reg.wready;
  assign bvalid              = st_reg.bvalid;
  assign bresp               = st_reg.bresp;
  assign arready             = st_reg.arready;
  assign rvalid              = st_reg.rvalid;
  assign rdata               = st_reg.rdata;
  assign rresp               = st_reg.rresp;
  assign can_tx_pin          = st_reg.tx_latch;
  assign can_tx_oe           = st_reg.tx_dir;  // R4
  assign fetch_to_test_flash = st_reg.redirect;
  assign ram_wr              = st_reg.ram;
  assign branch_start        = st_reg.branch;
  assign ack_obj             = st_reg.ack;
  assign boot_mode           = st_reg.boot;
  assign watchdog_disable    = st_reg.boot;  // R1
  assign system_config       = st_reg.sys_cfg;
  assign bus_config_zero     = st_reg.bus_cfg;
  assign periph_select       = st_reg.periph;
  assign can_control_status  = st_reg.ctrl;
  assign can_bit_timing      = st_reg.btr;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_watchdog_off: assert property (st_reg.state == ST_LOAD |-> watchdog_disable && boot_mode)  // R1
    else $error("watchdog enabled during load");
  a_periph_entry: assert property ($past(st_reg.state) == ST_STRAP && st_reg.state == ST_POLL
    |-> periph_select == PERIPH_BOOT && system_config[MEM_EN_BIT])  // R2
    else $error("boot entry config wrong");
  a_bus_config: assert property ($past(st_reg.state) == ST_STRAP && st_reg.state == ST_POLL
    |-> bus_config_zero[BUS_ACT_BIT] == !$past(st_reg.s2[5]))  // R7
    else $error("bus config zero wrong for access pin");
  a_can_setup: assert property ($rose(st_reg.ack.valid)
    |-> can_control_status == CTRL_BOOT && can_tx_pin && can_tx_oe && can_bit_timing[7:6] == SJW_CODE)  // R3
    else $error("can setup incomplete at acknowledge");
  a_quanta_range: assert property ($rose(st_reg.state == ST_LOAD)
    |-> (can_bit_timing[14:12] + can_bit_timing[11:8] + 3) inside {[TQ_MIN:TQ_MAX]})  // R18
    else $error("bit time quanta out of range");
  a_ram_window: assert property (ram_wr.we |-> ram_wr.addr >= RAM_BASE && ram_wr.addr <= RAM_LAST)  // R10
    else $error("load write outside window");
  a_branch_after: assert property (branch_start |-> st_reg.loaded == 8'(LOAD_BYTES) ##1 !branch_start
    && st_reg.state == ST_RUN)  // R11
    else $error("branch not after full load");
  a_fetch_redirect: assert property (boot_mode && fetch.req && fetch.code && fetch.addr == FLASH_LO
    |=> fetch_to_test_flash)  // R12
    else $error("flash fetch not redirected");
  a_timer_step: assert property (st_reg.state inside {ST_DOM, ST_REC} && $past(st_reg.state) inside {ST_DOM, ST_REC}
    && st_reg.state == $past(st_reg.state) |-> st_reg.count == $past(st_reg.count) + 1'b1)  // R16
    else $error("timer not stepping each clock");
  a_stuff_stop: assert property (st_reg.state == ST_CALC |-> st_reg.stuff == STUFF_LAST)  // R15
    else $error("timer stopped at wrong stuff bit");

  c_load_done: cover property (branch_start);
  c_bad_rate: cover property ($rose(st_reg.bad_rate));
  c_uart_meas: cover property (st_reg.state == ST_UART ##1 st_reg.state == ST_POLL);
  c_normal: cover property (st_reg.state == ST_NORMAL);
endmodule : can_boot_bitrate_loader
`default_nettype wire

/* verification/can_host_model.sv */
// Model of the CAN host: zero frame on the receive line, boot frames to the controller
`default_nettype none
module can_host_model (
  input  wire logic                  aclk,
  output var  logic                  can_rx_pin,
  output var  can_boot_pkg::rx_frame_t rx_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  import can_boot_pkg::*;

  // Bus idles recessive through its pull-up
  initial begin
    can_rx_pin = 1'b1;
    rx_frame = '0;
  end

  task automatic level(input logic l, input int n);
    can_rx_pin <= l;
    repeat (n) @(posedge aclk);
  endtask : level

  // Identifier 0, length 0: dominant runs broken by stuff bits
  task automatic zero_frame(input int bc);
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      level(1'b0, 5 * bc);
      level(1'b1, bc);
    end
    level(1'b0, 4 * bc);
    level(1'b1, bc);
    level(1'b0, bc);
    level(1'b1, 11 * bc);
  endtask : zero_frame

  // One data byte per frame; consecutive calls give back to back frames
  task automatic send_frame(input logic [10:0] id, input logic [7:0] d);
    @(posedge aclk);
    rx_frame <= '{1'b1, id, d};
  endtask : send_frame

  // Released payload does not keep its last value
  task automatic idle();
    @(posedge aclk);
    rx_frame <= '{1'b0, ~rx_frame.id, ~rx_frame.data};
  endtask : idle
endmodule : can_host_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench of the CAN boot bit rate loader
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import can_boot_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  bresp, rresp, bus_type_pins = 2'h2;
  logic        boot_select_n = 1'b0, external_access_pin = 1'b1, bus_width_pin = 1'b1, uart_rx_pin = 1'b1;
  logic        can_rx_pin, can_tx_pin, can_tx_oe, fetch_to_test_flash, branch_start, boot_mode, watchdog_disable;
  rx_frame_t   rx_frame;
  fetch_t      fetch = '0;
  ram_wr_t     ram_wr;
  ack_obj_t    ack_obj;
  logic [15:0] system_config, bus_config_zero, periph_select, can_control_status, can_bit_timing;
  int          n_fail = 0, check_count = 0, n_wr = 0, n_br = 0;
  logic [31:0] seed = 32'h48;
  logic [7:0]  img [128];
  localparam logic [23:0] FA [5] = '{24'h010000, 24'h08ffff, 24'h00ffff, 24'h090000, 24'h020000};
  localparam logic [4:0]  FC = 5'h0f, FX = 5'h03;

  always #25 aclk = ~aclk;

  can_boot_bitrate_loader can_boot_bitrate_loader_i (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .boot_select_n, .external_access_pin,
    .bus_width_pin, .bus_type_pins, .uart_rx_pin, .can_rx_pin, .can_tx_pin, .can_tx_oe, .rx_frame, .fetch,
    .fetch_to_test_flash, .ram_wr, .branch_start, .ack_obj, .boot_mode, .watchdog_disable, .system_config,
    .bus_config_zero, .periph_select, .can_control_status, .can_bit_timing);
  can_host_model can_host_model_i (.aclk, .can_rx_pin, .rx_frame);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected bit timing word from a measured count
  function automatic logic [15:0] exp_btr(input int cnt);
    int bit_rate_prescaler, dv, tq, s2;
    bit_rate_prescaler = cnt / BRP_DIV;
    dv = TQ_TICKS * (bit_rate_prescaler + 1);
    tq = cnt / dv + ((2 * (cnt % dv) > dv) ? 1 : 0);
    s2 = (tq + 4) / 5;
    if (tq - 17 > s2) s2 = tq - 17;
    return {1'b0, 3'(s2 - 1), 4'(tq - 2 - s2), 2'h1, 6'(bit_rate_prescaler)};
  endfunction : exp_btr

  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 5000) begin
        n_fail++;
        print_verdict();
      end
    end while (s !== 1'b1);
  endtask : wait_hi

  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d);
    logic tw;
    @(posedge aclk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    wait_hi(awready);
    tw = wready;
    @(posedge aclk);
    awvalid <= 1'b0;
    if (!tw) begin
      wait_hi(wready);
      @(posedge aclk);
    end
    wvalid <= 1'b0;
    wait_hi(bvalid);
    chk(bresp, RESP_OKAY);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    wait_hi(arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  // Stored bytes and the branch pulse
  always @(negedge aclk) begin
    if (aresetn && ram_wr.we === 1'b1) begin
      chk({ram_wr.addr, ram_wr.data}, {16'hfa40 + 16'(n_wr), img[n_wr]});
      n_wr++;
    end
    if (aresetn && branch_start === 1'b1) begin
      n_br++;
      chk(n_wr, 128);
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    int          k;
    for (int e = 2; e >= 0; e--) begin
      @(posedge aclk);
      aresetn <= 1'b0;
      external_access_pin <= e[0];
      boot_select_n <= e[1];
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (12) @(posedge aclk);
      @(negedge aclk);
      if (e[1]) begin
        chk({watchdog_disable, boot_mode, periph_select}, 18'h0);
      end else begin
        chk(bus_config_zero, e ? 16'h0000 : 16'h0680);
        chk({system_config[10:9], system_config[2]}, 3'h7);
        chk(periph_select, 16'h042d);
        chk({watchdog_disable, boot_mode}, 2'h3);
      end
      // Prescaler one with a rounded up quanta count, cleared again by the next reset
      if (e == 1) begin
        can_host_model_i.zero_frame(51);
        wait_hi(can_tx_oe);
        chk(can_bit_timing, exp_btr(29 * 51));
      end
    end
    axi_rd({IDX_PERIPH, 2'h0}, d, r);
    chk(d, 32'h042d);
    axi_rd({IDX_CTRL, 2'h0}, d, r);
    chk(d, 32'h0);
    axi_rd({16'h0100, 2'h0}, d, r);
    chk(r, RESP_SLVERR);
    @(posedge aclk);
    uart_rx_pin <= 1'b0;
    repeat (40) @(posedge aclk);
    uart_rx_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_rd({IDX_UART, 2'h0}, d, r);
    chk(d >= 34 && d <= 46, 1);
    can_host_model_i.zero_frame(20);
    wait_hi(can_tx_oe);
    chk(can_bit_timing, exp_btr(29 * 20));
    chk({can_control_status, can_tx_pin, can_tx_oe}, 18'h3);
    chk({ack_obj.valid, ack_obj.id, ack_obj.dlc}, {1'b1, 11'h0e6, 4'h3});
    chk(ack_obj.data, 24'h0a5c3c);
    axi_rd({IDX_COUNT, 2'h0}, d, r);
    chk(d >= 574 && d <= 586, 1);
    axi_wr({IDX_BTR, 2'h0}, 32'h1600);
    axi_rd({IDX_BTR, 2'h0}, d, r);
    chk(d, 32'h1600);
    foreach (img[i]) img[i] = 8'(xs());
    k = 0;
    while (k < 128) begin
      v = 8'(xs());
      if (v[7:6] == 2'h0) begin
        can_host_model_i.send_frame(11'h005 ^ {3'h0, v | 8'h01}, v);
      end else begin
        can_host_model_i.send_frame(11'h005, img[k]);
        k++;
      end
      if (v[0]) can_host_model_i.idle();
    end
    can_host_model_i.send_frame(11'h005, 8'h55);
    can_host_model_i.idle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(n_wr, 32'd128);
    chk(n_br, 32'd1);
    chk(boot_mode, 1'b1);
    foreach (FA[i]) begin
      @(posedge aclk);
      fetch <= '{1'b1, FC[i], FA[i]};
      @(posedge aclk);
      fetch.req <= 1'b0;
      @(negedge aclk);
      chk(fetch_to_test_flash, FX[i]);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
